// >>> src/xie_regs.svh
// Constants for the external and system management interrupt entry block.
`ifndef XIE_REGS_SVH
`define XIE_REGS_SVH

// ----------------------------------------------------------------------
// Machine-state bit positions (index 0 is the least significant bit)
// ----------------------------------------------------------------------
`define XIE_MS_POW 18
`define XIE_MS_TEMP_GPR_REMAP 17
`define XIE_MS_ILE 16
`define XIE_MS_EE 15
`define XIE_MS_PR 14
`define XIE_MS_FP 13
`define XIE_MS_ME 12
`define XIE_MS_FE0 11
`define XIE_MS_SE 10
`define XIE_MS_BE 9
`define XIE_MS_FE1 8
`define XIE_MS_IP 6
`define XIE_MS_IR 5
`define XIE_MS_DR 4
`define XIE_MS_RI 1
`define XIE_MS_LE 0

// ----------------------------------------------------------------------
// Entry masks, reset values and vectors
// ----------------------------------------------------------------------
`define XIE_SAVE_COPY_MASK 32'h87c0ffff
`define XIE_MS_CLEAR_MASK 32'h0006ef33
`define XIE_MS_RESET 32'h00000040
`define XIE_BASE_LOW 32'h00000000
`define XIE_BASE_HIGH 32'hfff00000
`define XIE_VEC_EXT 32'h00000500
`define XIE_VEC_SMI 32'h00001400

// ----------------------------------------------------------------------
// Requester register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define XIE_REG_REQ 8'h00
`define XIE_REG_ACK 8'h04
`define XIE_REG_EVT 8'h08
`define XIE_REG_MASK 8'h0c
`define XIE_REG_ID 8'h10
`define XIE_BIT_EXT 0
`define XIE_BIT_SMI 1
`define XIE_ID_VALUE 32'h00005a5a

`endif

// >>> src/xie_pkg.sv
// Types used by the processor-side entry logic of the interrupt entry block.
package xie_pkg;

    typedef enum logic [1:0] {
        XIE_IDLE,
        XIE_DRAIN,
        XIE_TAKE
    } xie_state_t;

    typedef enum logic {
        XIE_KIND_EXT,
        XIE_KIND_SMI
    } xie_kind_t;

endpackage : xie_pkg

// >>> src/xie_if.sv
// Interrupt request lines between a requesting device and the processor.
`timescale 1ns/10ps

interface xie_if;
    logic ext_req_n;
    logic sys_mgmt_req_n;

    modport dev (
        input ext_req_n,
        input sys_mgmt_req_n
    );

    modport req (
        output ext_req_n,
        output sys_mgmt_req_n
    );
endinterface : xie_if

// >>> src/xie_entry.sv
// Processor-side entry logic for external and system management interrupts.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "xie_regs.svh"

module xie_entry (
    input wire logic clock,
    input wire logic rst,
    xie_if.dev link,
    input wire logic hi_prio_pending,
    input wire logic [3:0] in_flight,
    input wire logic instr_complete,
    input wire logic next_pc_valid,
    input wire logic [31:0] next_pc,
    input wire logic [31:0] alt_pc,
    input wire logic ms_wr,
    input wire logic [31:0] ms_wdata,
    input wire logic resume,
    output logic [31:0] machine_state,
    output logic [31:0] saved_pc,
    output logic [31:0] saved_status,
    output logic dispatch_stall,
    output logic entry_take,
    output logic entry_smi,
    output logic [31:0] entry_vector
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // The enable bit gates both requests, so one function serves both.
    function automatic logic recognised(input logic req_n,
                                        input logic [31:0] ms);
        recognised = ~req_n & ms[`XIE_MS_EE];
    endfunction : recognised

    function automatic logic [31:0] base_of(input logic [31:0] ms);
        base_of = ms[`XIE_MS_IP] ? `XIE_BASE_HIGH : `XIE_BASE_LOW;
    endfunction : base_of

    // ------------------------------------------------------------------
    // Request synchronisers
    // ------------------------------------------------------------------
    logic ext_meta_q;
    logic ext_sync_q;
    logic smi_meta_q;
    logic smi_sync_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_meta_q <= 1'b1;
            ext_sync_q <= 1'b1;
            smi_meta_q <= 1'b1;
            smi_sync_q <= 1'b1;
        end else begin
            ext_meta_q <= link.ext_req_n;
            ext_sync_q <= ext_meta_q;
            smi_meta_q <= link.sys_mgmt_req_n;
            smi_sync_q <= smi_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Recognition and entry sequencing
    // ------------------------------------------------------------------
    xie_pkg::xie_state_t state_q;
    xie_pkg::xie_kind_t kind_q;
    logic [31:0] machine_state_q;
    logic [31:0] saved_pc_q;
    logic [31:0] saved_status_q;
    logic stall_q;
    logic take_q;
    logic smi_q;
    logic [31:0] vector_q;
    logic ext_rec;
    logic smi_rec;
    logic drained;
    logic still_wanted;
    logic take_smi;

    assign ext_rec = recognised(ext_sync_q, machine_state_q);
    assign smi_rec = recognised(smi_sync_q, machine_state_q);
    // An external request waits for every executing instruction, while a
    // system management request only needs the next one to finish.
    assign drained = (kind_q == xie_pkg::XIE_KIND_SMI)
                     ? (instr_complete || in_flight == 4'h0)
                     : (in_flight == 4'h0);
    assign still_wanted = smi_rec || ext_rec;
    assign take_smi = smi_rec;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= xie_pkg::XIE_IDLE;
            kind_q <= xie_pkg::XIE_KIND_EXT;
        end else begin
            unique case (state_q)
                xie_pkg::XIE_IDLE: begin
                    if (smi_rec) begin
                        state_q <= xie_pkg::XIE_DRAIN;
                        kind_q <= xie_pkg::XIE_KIND_SMI;
                    end else if (ext_rec) begin
                        state_q <= xie_pkg::XIE_DRAIN;
                        kind_q <= xie_pkg::XIE_KIND_EXT;
                    end
                end
                xie_pkg::XIE_DRAIN: begin
                    // A request dropped before entry need not be taken.
                    if (!still_wanted) begin
                        state_q <= xie_pkg::XIE_IDLE;
                    end else if (drained && !hi_prio_pending) begin
                        state_q <= xie_pkg::XIE_TAKE;
                    end
                    if (smi_rec) begin
                        kind_q <= xie_pkg::XIE_KIND_SMI;
                    end
                end
                xie_pkg::XIE_TAKE: begin
                    state_q <= xie_pkg::XIE_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Dispatch stall
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stall_q <= 1'b0;
        end else begin
            // The stall also covers the take cycle, so that nothing is
            // dispatched between the end of the drain and the entry.
            stall_q <= (state_q == xie_pkg::XIE_IDLE && smi_rec) ||
                       (state_q == xie_pkg::XIE_IDLE && ext_rec) ||
                       (state_q == xie_pkg::XIE_DRAIN &&
                        still_wanted);
        end
    end

    // ------------------------------------------------------------------
    // Architectural state updates on entry
    // ------------------------------------------------------------------
    // Entry is decided in the take state from the live recognition so
    // that a system management request arriving late still wins; if both
    // requests vanished in that one cycle the entry is dropped.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            machine_state_q <= `XIE_MS_RESET;
            saved_pc_q <= 32'h00000000;
            saved_status_q <= 32'h00000000;
        end else if (state_q == xie_pkg::XIE_TAKE && still_wanted) begin
            saved_pc_q <= next_pc_valid ? next_pc : alt_pc;
            saved_status_q <= machine_state_q &
                              `XIE_SAVE_COPY_MASK;
            machine_state_q <= (machine_state_q & ~`XIE_MS_CLEAR_MASK) |
                               {31'h00000000,
                                machine_state_q[`XIE_MS_ILE]};
        end else if (resume) begin
            machine_state_q <= saved_status_q;
        end else if (ms_wr) begin
            machine_state_q <= ms_wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            take_q <= 1'b0;
            smi_q <= 1'b0;
            vector_q <= 32'h00000000;
        end else begin
            take_q <= state_q == xie_pkg::XIE_TAKE && still_wanted;
            if (state_q == xie_pkg::XIE_TAKE && still_wanted) begin
                smi_q <= take_smi;
                if (take_smi) begin
                    vector_q <= base_of(machine_state_q) |
                                `XIE_VEC_SMI;
                end else begin
                    vector_q <= base_of(machine_state_q) |
                                `XIE_VEC_EXT;
                end
            end
        end
    end

    // The request lines are inputs only; entry leaves them to the
    // requester, which negates them on the handler's acknowledge.
    assign machine_state = machine_state_q;
    assign saved_pc = saved_pc_q;
    assign saved_status = saved_status_q;
    assign dispatch_stall = stall_q;
    assign entry_take = take_q;
    assign entry_smi = smi_q;
    assign entry_vector = vector_q;

endmodule : xie_entry

// >>> src/xie_requester.sv
// Interrupt requester: holds request lines until software acknowledges.
`timescale 1ns/10ps
`include "xie_regs.svh"

module xie_requester (
    input wire logic clock,
    input wire logic rst,
    xie_if.req link,
    input wire logic ext_event,
    input wire logic smi_event,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdata_q;
    logic [1:0] req_q;
    logic [1:0] evt_q;
    logic [1:0] mask_q;
    logic irq_q;
    logic wr;
    logic [1:0] wbits;

    // Writes land at the edge where the master samples ack high, so the
    // write and its acknowledge are seen by both sides at the same edge.
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
    assign wbits = wb_dat_i[1:0];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            unique case (wb_adr_i)
                `XIE_REG_REQ: rdata_q <= {30'h00000000, req_q};
                `XIE_REG_EVT: rdata_q <= {30'h00000000, evt_q};
                `XIE_REG_MASK: rdata_q <= {30'h00000000, mask_q};
                `XIE_REG_ID: rdata_q <= `XIE_ID_VALUE;
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Request lines
    // ------------------------------------------------------------------
    // A request is a level held until the handler's acknowledge write;
    // a new event in the same cycle as the acknowledge keeps it raised.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_q <= 2'h0;
        end else begin
            req_q[`XIE_BIT_EXT] <= ext_event || (wr &&
                wb_adr_i == `XIE_REG_REQ && wbits[`XIE_BIT_EXT]) ||
                (req_q[`XIE_BIT_EXT] && !(wr && wb_adr_i == `XIE_REG_ACK &&
                wbits[`XIE_BIT_EXT]));
            req_q[`XIE_BIT_SMI] <= smi_event || (wr &&
                wb_adr_i == `XIE_REG_REQ && wbits[`XIE_BIT_SMI]) ||
                (req_q[`XIE_BIT_SMI] && !(wr && wb_adr_i == `XIE_REG_ACK &&
                wbits[`XIE_BIT_SMI]));
        end
    end

    // ------------------------------------------------------------------
    // Event status, mask and interrupt
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evt_q <= 2'h0;
        end else begin
            evt_q <= {smi_event, ext_event} |
                     (evt_q & ~((wr && wb_adr_i == `XIE_REG_EVT) ?
                     wbits : 2'h0));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_q <= 2'h0;
        end else if (wr && wb_adr_i == `XIE_REG_MASK) begin
            mask_q <= wbits;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & mask_q);
        end
    end

    assign link.ext_req_n = ~req_q[`XIE_BIT_EXT];
    assign link.sys_mgmt_req_n = ~req_q[`XIE_BIT_SMI];
    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign irq = irq_q;

endmodule : xie_requester

// >>> tb/xie_entry_assertions.sv
// Concurrent checks on the request lines and the interrupt entry outputs.
`timescale 1ns/10ps
`include "xie_regs.svh"

module xie_entry_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic ext_req_n,
    input wire logic sys_mgmt_req_n,
    input wire logic hi_prio_pending,
    input wire logic [3:0] in_flight,
    input wire logic next_pc_valid,
    input wire logic [31:0] next_pc,
    input wire logic [31:0] alt_pc,
    input wire logic [31:0] machine_state,
    input wire logic [31:0] saved_pc,
    input wire logic [31:0] saved_status,
    input wire logic dispatch_stall,
    input wire logic entry_take,
    input wire logic entry_smi,
    input wire logic [31:0] entry_vector
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Entry sequences
    // ------------------------------------------------------------------
    sequence s_ext_take;
        entry_take && !entry_smi;
    endsequence
    sequence s_smi_take;
        entry_take && entry_smi;
    endsequence

    // The vector base bit survives entry, so the base is read afterwards.
    ext_vec_a: assert property (s_ext_take |-> entry_vector ==
        ((machine_state[`XIE_MS_IP] ? `XIE_BASE_HIGH : `XIE_BASE_LOW)
        + `XIE_VEC_EXT)) else $error("external vector wrong");
    smi_vec_a: assert property (s_smi_take |-> entry_vector ==
        ((machine_state[`XIE_MS_IP] ? `XIE_BASE_HIGH : `XIE_BASE_LOW)
        + `XIE_VEC_SMI)) else $error("system management vector wrong");
    status_copy_a: assert property (entry_take |->
        (saved_status & ~`XIE_SAVE_COPY_MASK) == 32'h00000000)
        else $error("saved status holds cleared bits");
    state_clear_a: assert property (entry_take |->
        (machine_state & `XIE_MS_CLEAR_MASK &
        ~(32'h1 << `XIE_MS_LE)) == 32'h00000000
        && machine_state[`XIE_MS_LE] == machine_state[`XIE_MS_ILE])
        else $error("machine state not rewritten");
    pc_pick_a: assert property (entry_take |-> saved_pc ==
        ($past(next_pc_valid) ? $past(next_pc) : $past(alt_pc)))
        else $error("saved pc source wrong");
    drain_first_a: assert property (entry_take |->
        $past(dispatch_stall, 2) && !$past(hi_prio_pending, 2))
        else $error("entry without drain");
    ext_drain_a: assert property (s_ext_take |->
        $past(in_flight, 2) == 4'h0) else $error("entry with work in flight");
    smi_first_a: assert property (s_ext_take |->
        $past(sys_mgmt_req_n, 3)) else $error("external taken over smi");
    req_seen_a: assert property (entry_take |->
        !$past(ext_req_n && sys_mgmt_req_n, 3)
        && $past(machine_state[`XIE_MS_EE], 2))
        else $error("entry without enabled request");
    sync_delay_a: assert property ($fell(ext_req_n) && !dispatch_stall
        |-> !dispatch_stall [*2]) else $error("request not synchronised");
    line_kept_a: assert property (entry_take |->
        $stable(ext_req_n) && $stable(sys_mgmt_req_n))
        else $error("entry disturbed request lines");
    smi_take_c: cover property (s_smi_take);
endmodule : xie_entry_assertions

// >>> tb/xie_entry_tb.sv
// Self-checking bench joining the requester and the entry logic.
`timescale 1ns/10ps
`include "xie_regs.svh"
`define XIE_CHK(g, e) check_val(32'(g), 32'(e));

module xie_entry_tb;
    logic clock = 1'b0, rst = 1'b1, hi_prio_pending = 1'b0;
    logic [3:0] in_flight = 4'h0;
    logic instr_complete = 1'b0, next_pc_valid = 1'b0, ms_wr = 1'b0;
    logic [31:0] next_pc = 32'h0, alt_pc = 32'h0, ms_wdata = 32'h0;
    logic ext_event = 1'b0, smi_event = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
    logic wb_we = 1'b0, resume = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0, wb_dat_o, machine_state, saved_pc;
    logic [31:0] saved_status, entry_vector, seed = 32'h000170c4;
    logic wb_ack_o, irq, dispatch_stall, entry_take, entry_smi;
    logic [1:0] lines_q = 2'h0;
    logic [31:0] exp_q[$];
    int mismatches = 0, cmp_count = 0, takes = 0;

    always #12.5 clock = ~clock;

    xie_if xie_if_i ();
    xie_entry xie_entry_i (.clock(clock), .rst(rst), .link(xie_if_i),
        .hi_prio_pending(hi_prio_pending), .in_flight(in_flight),
        .instr_complete(instr_complete), .next_pc_valid(next_pc_valid),
        .next_pc(next_pc), .alt_pc(alt_pc), .ms_wr(ms_wr),
        .ms_wdata(ms_wdata), .resume(resume), .machine_state(machine_state),
        .saved_pc(saved_pc), .saved_status(saved_status),
        .dispatch_stall(dispatch_stall), .entry_take(entry_take),
        .entry_smi(entry_smi), .entry_vector(entry_vector));
    xie_requester xie_requester_i (.clock(clock), .rst(rst),
        .link(xie_if_i), .ext_event(ext_event), .smi_event(smi_event),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
    xie_entry_assertions xie_entry_assertions_i (.clock(clock), .rst(rst),
        .ext_req_n(xie_if_i.ext_req_n),
        .sys_mgmt_req_n(xie_if_i.sys_mgmt_req_n),
        .hi_prio_pending(hi_prio_pending), .in_flight(in_flight),
        .next_pc_valid(next_pc_valid), .next_pc(next_pc), .alt_pc(alt_pc),
        .machine_state(machine_state), .saved_pc(saved_pc),
        .saved_status(saved_status), .dispatch_stall(dispatch_stall),
        .entry_take(entry_take), .entry_smi(entry_smi),
        .entry_vector(entry_vector));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] pop();
        if (exp_q.size() == 0) return 'x;
        return exp_q.pop_front();
    endfunction : pop

    // Each value is evaluated once, so a popped note is never lost.
    task automatic check_val(input logic [31:0] got,
                             input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_val

    // ------------------------------------------------------------------
    // Result watcher
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (entry_take === 1'b1) begin
            takes <= takes + 1;
            `XIE_CHK(entry_vector, pop())
            `XIE_CHK(saved_pc, pop())
            `XIE_CHK(saved_status, pop())
            `XIE_CHK(machine_state, pop())
            `XIE_CHK(entry_smi, pop())
        end
        if (wb_ack_o === 1'b1 && !wb_we) `XIE_CHK(wb_dat_o, pop())
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // A read notes its expected data before the cycle starts.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        if (!we) exp_q.push_back(d);
        @(posedge clock);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel} <= {2'b11, we, a, 4'hf};
        wb_dat <= we ? d : 32'h0;
        // Only the watchdog ends a wait for the acknowledge.
        do @(posedge clock);
        while (wb_ack_o !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    // Raises the lines in req and runs one entry with nfl still executing.
    task automatic entry(input logic [1:0] req, input logic [3:0] nfl,
                         input logic pcv);
        logic [31:0] ms, np, ap, ns;
        logic [1:0] a;
        int n, k;
        ms = rnd() | (32'h1 << `XIE_MS_EE);
        np = rnd();
        ap = rnd();
        lines_q = lines_q | req;
        a = lines_q[1] ? 2'b10 : 2'b01;
        @(posedge clock);
        {ms_wr, ms_wdata, in_flight, hi_prio_pending} <= {1'b1, ms, nfl, 1'b1};
        {next_pc, alt_pc, next_pc_valid} <= {np, ap, pcv};
        @(posedge clock);
        ms_wr <= 1'b0;
        ns = ms & ~`XIE_MS_CLEAR_MASK;
        ns[`XIE_MS_LE] = ms[`XIE_MS_ILE];
        exp_q.push_back((ms[`XIE_MS_IP] ? `XIE_BASE_HIGH : `XIE_BASE_LOW)
            + (a[1] ? `XIE_VEC_SMI : `XIE_VEC_EXT));
        exp_q.push_back(pcv ? np : ap);
        exp_q.push_back(ms & `XIE_SAVE_COPY_MASK);
        exp_q.push_back(ns);
        exp_q.push_back({31'h0, a[1]});
        n = takes;
        wb(1'b1, `XIE_REG_REQ, {30'h0, req});
        repeat (8) @(posedge clock);
        `XIE_CHK(dispatch_stall, 1'b1)
        `XIE_CHK(takes, n)
        hi_prio_pending <= 1'b0;
        repeat (4) @(posedge clock);
        // With nothing in flight the entry follows the pending exception.
        `XIE_CHK(takes, n + int'(nfl == 4'h0))
        if (a[1]) instr_complete <= 1'b1;
        else in_flight <= 4'h0;
        @(posedge clock);
        instr_complete <= 1'b0;
        for (k = 0; k < 40 && takes == n; k++) @(posedge clock);
        `XIE_CHK(takes, n + 1)
        in_flight <= 4'h0;
        wb(1'b0, `XIE_REG_REQ, {30'h0, lines_q});
        wb(1'b1, `XIE_REG_ACK, {30'h0, a});
        lines_q = lines_q & ~a;
        wb(1'b0, `XIE_REG_REQ, {30'h0, lines_q});
        // Resume only when no line is left low, or it would re-enter.
        if (lines_q == 2'b00) begin
            resume <= 1'b1;
            @(posedge clock);
            resume <= 1'b0;
            @(posedge clock);
            `XIE_CHK(machine_state, ms & `XIE_SAVE_COPY_MASK)
        end
    endtask : entry

    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        `XIE_CHK(machine_state, `XIE_MS_RESET)
        wb(1'b0, `XIE_REG_ID, `XIE_ID_VALUE);
        wb(1'b0, 8'h20, 32'h0);
        wb(1'b1, `XIE_REG_MASK, 32'h3);
        wb(1'b0, `XIE_REG_MASK, 32'h3);
        {ext_event, smi_event} <= 2'b11;
        @(posedge clock);
        {ext_event, smi_event} <= 2'b00;
        repeat (3) @(posedge clock);
        `XIE_CHK(irq, 1'b1)
        wb(1'b1, `XIE_REG_MASK, 32'h0);
        repeat (2) @(posedge clock);
        `XIE_CHK(irq, 1'b0)
        wb(1'b1, `XIE_REG_MASK, 32'h3);
        wb(1'b0, `XIE_REG_EVT, 32'h3);
        wb(1'b1, `XIE_REG_EVT, 32'h3);
        wb(1'b0, `XIE_REG_EVT, 32'h0);
        `XIE_CHK(irq, 1'b0)
        // Lines are low but the enable bit is still clear after reset.
        wb(1'b0, `XIE_REG_REQ, 32'h3);
        repeat (10) @(posedge clock);
        `XIE_CHK(takes, 0)
        wb(1'b1, `XIE_REG_ACK, 32'h3);
        wb(1'b0, `XIE_REG_REQ, 32'h0);
        entry(2'b01, 4'h3, 1'b1);
        entry(2'b11, 4'h2, 1'b0);
        entry(2'b01, 4'h0, 1'b1);
        entry(2'b10, 4'h5, 1'b1);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        complete_run();
    end
endmodule : xie_entry_tb
